/* src/erf_pkg.sv */
package erf_pkg;
// Summary of operation
// - Management data pin is input after reset
// - Device drives management clock; data follows it
// - Frame valid rises at preamble, falls promptly
// - Data valid only with frame valid; serial mode
// - Receive ring pointer bits 1-0 read zero
// - Transmit ring pointer ignores two lowest bits
// - Buffer size bits 3-0 forced to zero
// - CRC bytes always land in last buffer; here they are counted as data and can span two buffers
// - Group or individual from I/G bit
// - Broadcast accepted when broadcast reject clear
// - Multicast looked up in group hash table
// - PAUSE frames detected and rejected with flow control
// - Unicast exact match, then individual hash lookup
// - No match: promiscuous accepts with miss flag
// - Rejected broadcast accepted only when promiscuous
// - Rejected frames flushed from receive FIFO

   // Timing
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned MDC_HALF_NS   = 200;
   localparam int unsigned MDC_HALF_CYC  = (MDC_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Register offsets
   localparam int unsigned ADDR_W       = 8;
   localparam logic [7:0]  OFF_RCV_CTRL = 8'h00;
   localparam logic [7:0]  OFF_RX_RING  = 8'h04;
   localparam logic [7:0]  OFF_TX_RING  = 8'h08;
   localparam logic [7:0]  OFF_BUF_SIZE = 8'h0c;
   localparam logic [7:0]  OFF_GRP_HI   = 8'h10;
   localparam logic [7:0]  OFF_GRP_LO   = 8'h14;
   localparam logic [7:0]  OFF_IND_HI   = 8'h18;
   localparam logic [7:0]  OFF_IND_LO   = 8'h1c;
   localparam logic [7:0]  OFF_STA_LO   = 8'h20;
   localparam logic [7:0]  OFF_STA_HI   = 8'h24;
   localparam logic [7:0]  OFF_MG_FRAME = 8'h28;
   localparam logic [7:0]  OFF_MG_STAT  = 8'h2c;

   // Field layout
   localparam int unsigned RC_PROMISCUOUS_ACCEPT_BIT  = 3;
   localparam int unsigned RC_BCREJ_BIT = 4;
   localparam int unsigned RC_FCEN_BIT  = 5;
   localparam int unsigned RC_SER_BIT   = 6;
   localparam int unsigned RC_MAXFL_LSB = 16;
   localparam int unsigned MAXFL_W      = 11;
   localparam logic [10:0] MAX_FRAME_LENGTH_RST   = 11'h5ee;
   localparam int unsigned RING_LSB     = 2;
   localparam int unsigned BUF_LSB      = 4;
   localparam int unsigned BUF_W        = 7;
   localparam logic [BUF_LSB-1:0] BUF_PAD = '0;
   localparam int unsigned STA_HI_LSB   = 16;
   localparam int unsigned ST_DONE_BIT  = 0;
   localparam int unsigned ST_BUSY_BIT  = 1;

   // Management frame layout
   localparam int unsigned MG_OP_MSB    = 29;
   localparam int unsigned MG_OP_LSB    = 28;
   localparam logic [1:0]  MG_OP_READ   = 2'h2;
   localparam logic [6:0]  MG_PRE_LAST  = 7'h1f;
   localparam logic [6:0]  MG_TA_BIT    = 7'h2e;
   localparam logic [6:0]  MG_DATA_BIT  = 7'h30;
   localparam logic [6:0]  MG_LAST_BIT  = 7'h3f;

   // Address recognition
   localparam logic [47:0] BCAST_DA = 48'hffff_ffff_ffff;
   localparam logic [47:0] PAUSE_DA = 48'h0180_c200_0001;
   localparam int unsigned IG_BIT   = 40;
   localparam int unsigned HASH_W   = 6;
   localparam logic [31:0] CRC_INIT = 32'hffff_ffff;
   localparam logic [31:0] CRC_POLY = 32'h04c1_1db7;

   // Management engine states
   typedef enum logic [0:0] {MG_IDLE, MG_SHIFT} erf_mg_state_t;
endpackage

/* src/erf_hash.sv */
module erf_hash
   import erf_pkg::*;
(
   // Destination address, first octet in the top byte
   input  wire logic [47:0]       da_i,
   // Hash table index
   output logic      [HASH_W-1:0] idx_o
);

   // CRC over the six octets, each octet least significant bit first
   always_comb
   begin
      logic [31:0] crc;
      logic        fb;
      crc = CRC_INIT;
      fb  = 1'b0;
      for (int b = 0; b < 6; b++)
      begin
         for (int i = 0; i < 8; i++)
         begin
            fb  = crc[31] ^ da_i[40 - 8*b + i];
            crc = {crc[30:0], 1'b0} ^ (fb ? CRC_POLY : 32'h0000_0000);
         end
      end
      // Top CRC bits pick one of the table bits
      idx_o = crc[31 -: HASH_W];
   end
endmodule

/* src/erf_top.sv */
// Decided for this implementation: the register addresses and the address-and-strobe port.
module erf_top
   import erf_pkg::*;
#(
   parameter int unsigned MDC_HALF = MDC_HALF_CYC
)
(
   // Clock and reset
   input  wire logic              sys_clk_i,
   input  wire logic              nrst_i,
   // Register port
   input  wire logic [ADDR_W-1:0] reg_addr_i,
   input  wire logic [31:0]       reg_wdata_i,
   input  wire logic              reg_wr_i,
   input  wire logic              reg_rd_i,
   output logic      [31:0]       reg_rdata_o,
   // Management pins
   output logic                   mgmt_data_clock_o,
   input  wire logic              mgmt_data_i,
   output logic                   mgmt_data_o,
   output logic                   mgmt_data_oe_o,
   // Transmit nibble source
   input  wire logic              tx_nib_valid_i,
   input  wire logic [3:0]        tx_nib_data_i,
   input  wire logic              tx_nib_err_i,
   output logic                   tx_nib_ready_o,
   // MII transmit pins
   input  wire logic              tx_nibble_clock_i,
   output logic                   tx_frame_valid_o,
   output logic      [3:0]        tx_nibble_data_o,
   output logic                   tx_error_out_o,
   // Receive address recognition
   input  wire logic              rx_da_valid_i,
   input  wire logic [47:0]       rx_da_i,
   input  wire logic              rx_pause_i,
   output logic                   rx_decide_o,
   output logic                   rx_accept_o,
   output logic                   rx_miss_o,
   output logic                   rx_flush_o,
   // Receive buffer fill
   input  wire logic              rx_byte_i,
   input  wire logic              rx_frame_end_i,
   output logic                   rx_buf_full_o,
   output logic                   rx_last_valid_o,
   output logic      [10:0]       rx_last_len_o,
   // Ring pointers for the descriptor engines
   output logic      [31:0]       rx_ring_start_o,
   output logic      [31:0]       tx_ring_start_o
);

   localparam int unsigned CNT_W = BUF_W + BUF_LSB;
   localparam logic [15:0] MDC_HALF_M1 = 16'(MDC_HALF - 1);

   // Divider must fit its counter and allow two phases
   if (MDC_HALF < 2 || MDC_HALF > 65535)
   begin : g_chk
      $error("MDC_HALF out of range");
   end

   // Whole module state
   typedef struct packed {
      logic [29:0]        rx_ring;     // Receive ring pointer
      logic [29:0]        tx_ring;     // Transmit ring pointer
      logic [BUF_W-1:0]   buf_size;    // Buffer size in 16-byte units
      logic               broadcast_reject;      // Broadcast reject
      logic               promiscuous_accept;        // Promiscuous accept
      logic               fc_en;       // Flow control enable
      logic               serial;      // 10 Mbps serial mode
      logic [MAXFL_W-1:0] max_frame_length;      // Maximum frame length
      logic [31:0]        grp_hi;      // Group hash upper
      logic [31:0]        grp_lo;      // Group hash lower
      logic [31:0]        ind_hi;      // Individual hash upper
      logic [31:0]        ind_lo;      // Individual hash lower
      logic [31:0]        sta_lo;      // Station address octets 0-3
      logic [15:0]        sta_hi;      // Station address octets 4-5
      erf_mg_state_t      mg_state;    // Management engine
      logic [31:0]        mg_shift;    // Outgoing frame bits
      logic               mg_read;     // Frame is a read
      logic [6:0]         mg_cnt;      // Bit position incl. preamble
      logic [15:0]        mg_div;      // Clock divider
      logic               mdc;         // Management clock
      logic               mdio_o;      // Pin drive value
      logic               mdio_oe;     // Pin drive enable
      logic               mdio_s1;     // Pin synchroniser stage 1
      logic               mdio_s2;     // Pin synchroniser stage 2
      logic [15:0]        mg_rdata;    // Read data from PHY
      logic               mg_done;     // Sticky transfer done
      logic               txc_s1;      // Tx clock stage 1
      logic               txc_s2;      // Tx clock stage 2
      logic               txc_s3;      // Tx clock edge history
      logic               txen;        // Frame valid pin
      logic [3:0]         txd;         // Nibble pins
      logic               txer;        // Error pin
      logic [CNT_W-1:0]   rx_cnt;      // Bytes in current buffer
      logic [CNT_W-1:0]   rx_last_len; // Bytes in last buffer
      logic               rx_full;     // Buffer full pulse
      logic               rx_end;      // Last length valid pulse
      logic               rx_decide;   // Decision pulse
      logic               rx_accept;   // Frame accepted
      logic               rx_miss;     // Accepted without a match
      logic               rx_flush;    // Flush pulse
      logic [31:0]        rdata;       // Read data
   } erf_state_t;

   erf_state_t        st_ff;       // Registered state
   erf_state_t        nxt_st;      // Next state
   logic [HASH_W-1:0] hash_idx;    // Hash index of destination
   logic              tx_rise;     // Tx clock rising edge seen
   logic              da_bcast;    // Broadcast destination
   logic              da_group;    // Group destination
   logic              da_exact;    // Matches station address
   logic              da_pause;    // Valid PAUSE frame
   logic              grp_hit;     // Group hash hit
   logic              ind_hit;     // Individual hash hit
   logic              dec_acc;     // Accept decision
   logic              dec_miss;    // Miss flag decision

   // Hash of the destination address
   erf_hash u_hash (
      .da_i  (rx_da_i),
      .idx_o (hash_idx)
   );

   // Destination classification
   always_comb
   begin
      da_bcast = (rx_da_i == BCAST_DA);
      da_group = rx_da_i[IG_BIT];
      da_exact = (rx_da_i == {st_ff.sta_lo, st_ff.sta_hi});
      da_pause = st_ff.fc_en && rx_pause_i
                 && ((rx_da_i == PAUSE_DA) || da_exact);
      grp_hit  = hash_idx[HASH_W-1] ? st_ff.grp_hi[hash_idx[HASH_W-2:0]]
                                    : st_ff.grp_lo[hash_idx[HASH_W-2:0]];
      ind_hit  = hash_idx[HASH_W-1] ? st_ff.ind_hi[hash_idx[HASH_W-2:0]]
                                    : st_ff.ind_lo[hash_idx[HASH_W-2:0]];
      dec_acc  = 1'b0;
      dec_miss = 1'b0;
      if (da_bcast)
      begin
         // Broadcast: open, or only through promiscuous
         if (!st_ff.broadcast_reject)
            dec_acc = 1'b1;
         else if (st_ff.promiscuous_accept)
         begin
            dec_acc  = 1'b1;
            dec_miss = 1'b1;
         end
      end
      else if (da_pause)
         dec_acc = 1'b0;
      else if ((da_group && grp_hit) || (!da_group && (da_exact || ind_hit)))
         dec_acc = 1'b1;
      else if (st_ff.promiscuous_accept)
      begin
         dec_acc  = 1'b1;
         dec_miss = 1'b1;
      end
   end

   assign tx_rise = st_ff.txc_s2 && !st_ff.txc_s3;

   // Next-state logic
   always_comb
   begin
      nxt_st           = st_ff;
      nxt_st.rdata     = '0;
      nxt_st.rx_full   = 1'b0;
      nxt_st.rx_end    = 1'b0;
      nxt_st.rx_decide = 1'b0;
      nxt_st.rx_flush  = 1'b0;
      // Synchronisers for pins from outside the clock
      nxt_st.mdio_s1   = mgmt_data_i;
      nxt_st.mdio_s2   = st_ff.mdio_s1;
      nxt_st.txc_s1    = tx_nibble_clock_i;
      nxt_st.txc_s2    = st_ff.txc_s1;
      nxt_st.txc_s3    = st_ff.txc_s2;

      // Register writes
      if (reg_wr_i)
      begin
         if (reg_addr_i == OFF_RCV_CTRL)
         begin
            nxt_st.promiscuous_accept   = reg_wdata_i[RC_PROMISCUOUS_ACCEPT_BIT];
            nxt_st.broadcast_reject = reg_wdata_i[RC_BCREJ_BIT];
            nxt_st.fc_en  = reg_wdata_i[RC_FCEN_BIT];
            nxt_st.serial = reg_wdata_i[RC_SER_BIT];
            nxt_st.max_frame_length = reg_wdata_i[RC_MAXFL_LSB +: MAXFL_W];
         end
         else if (reg_addr_i == OFF_RX_RING)
            nxt_st.rx_ring = reg_wdata_i[31:RING_LSB];
         else if (reg_addr_i == OFF_TX_RING)
            nxt_st.tx_ring = reg_wdata_i[31:RING_LSB];
         else if (reg_addr_i == OFF_BUF_SIZE)
            nxt_st.buf_size = reg_wdata_i[BUF_LSB +: BUF_W];
         else if (reg_addr_i == OFF_GRP_HI)
            nxt_st.grp_hi = reg_wdata_i;
         else if (reg_addr_i == OFF_GRP_LO)
            nxt_st.grp_lo = reg_wdata_i;
         else if (reg_addr_i == OFF_IND_HI)
            nxt_st.ind_hi = reg_wdata_i;
         else if (reg_addr_i == OFF_IND_LO)
            nxt_st.ind_lo = reg_wdata_i;
         else if (reg_addr_i == OFF_STA_LO)
            nxt_st.sta_lo = reg_wdata_i;
         else if (reg_addr_i == OFF_STA_HI)
            nxt_st.sta_hi = reg_wdata_i[STA_HI_LSB +: 16];
         else if (reg_addr_i == OFF_MG_FRAME && st_ff.mg_state == MG_IDLE)
         begin
            // Start a management frame; busy writes are dropped
            nxt_st.mg_state = MG_SHIFT;
            nxt_st.mg_shift = reg_wdata_i;
            nxt_st.mg_read  = (reg_wdata_i[MG_OP_MSB:MG_OP_LSB] == MG_OP_READ);
            nxt_st.mg_cnt   = '0;
            nxt_st.mg_div   = '0;
            nxt_st.mg_rdata = '0;
            nxt_st.mdc      = 1'b0;
            nxt_st.mdio_o   = 1'b1;
            nxt_st.mdio_oe  = 1'b1;
         end
         else if (reg_addr_i == OFF_MG_STAT && reg_wdata_i[ST_DONE_BIT])
            nxt_st.mg_done = 1'b0;
      end

      // Register reads, data in the following cycle only
      if (reg_rd_i)
      begin
         if (reg_addr_i == OFF_RCV_CTRL)
         begin
            nxt_st.rdata[RC_PROMISCUOUS_ACCEPT_BIT]  = st_ff.promiscuous_accept;
            nxt_st.rdata[RC_BCREJ_BIT] = st_ff.broadcast_reject;
            nxt_st.rdata[RC_FCEN_BIT]  = st_ff.fc_en;
            nxt_st.rdata[RC_SER_BIT]   = st_ff.serial;
            nxt_st.rdata[RC_MAXFL_LSB +: MAXFL_W] = st_ff.max_frame_length;
         end
         else if (reg_addr_i == OFF_RX_RING)
            nxt_st.rdata[31:RING_LSB] = st_ff.rx_ring;
         else if (reg_addr_i == OFF_TX_RING)
            nxt_st.rdata[31:RING_LSB] = st_ff.tx_ring;
         else if (reg_addr_i == OFF_BUF_SIZE)
            nxt_st.rdata[BUF_LSB +: BUF_W] = st_ff.buf_size;
         else if (reg_addr_i == OFF_GRP_HI)
            nxt_st.rdata = st_ff.grp_hi;
         else if (reg_addr_i == OFF_GRP_LO)
            nxt_st.rdata = st_ff.grp_lo;
         else if (reg_addr_i == OFF_IND_HI)
            nxt_st.rdata = st_ff.ind_hi;
         else if (reg_addr_i == OFF_IND_LO)
            nxt_st.rdata = st_ff.ind_lo;
         else if (reg_addr_i == OFF_STA_LO)
            nxt_st.rdata = st_ff.sta_lo;
         else if (reg_addr_i == OFF_STA_HI)
            nxt_st.rdata[STA_HI_LSB +: 16] = st_ff.sta_hi;
         else if (reg_addr_i == OFF_MG_FRAME)
            nxt_st.rdata[15:0] = st_ff.mg_rdata;
         else if (reg_addr_i == OFF_MG_STAT)
         begin
            nxt_st.rdata[ST_DONE_BIT] = st_ff.mg_done;
            nxt_st.rdata[ST_BUSY_BIT] = (st_ff.mg_state == MG_SHIFT);
         end
      end

      // Management engine: shift on falling clock, sample on rising
      case (st_ff.mg_state)
         MG_IDLE:
         begin
            nxt_st.mg_div = st_ff.mg_div;
         end
         MG_SHIFT:
         begin
            if (st_ff.mg_div == MDC_HALF_M1)
            begin
               nxt_st.mg_div = '0;
               nxt_st.mdc    = !st_ff.mdc;
               if (!st_ff.mdc)
               begin
                  // Rising edge: capture read data bits
                  if (st_ff.mg_read && st_ff.mg_cnt >= MG_DATA_BIT)
                     nxt_st.mg_rdata = {st_ff.mg_rdata[14:0], st_ff.mdio_s2};
               end
               else if (st_ff.mg_cnt == MG_LAST_BIT)
               begin
                  // Frame over: release pin, flag done
                  nxt_st.mg_state = MG_IDLE;
                  nxt_st.mdio_oe  = 1'b0;
                  nxt_st.mdio_o   = 1'b0;
                  nxt_st.mg_done  = 1'b1;
               end
               else
               begin
                  // Falling edge: next bit, preamble first
                  nxt_st.mg_cnt = st_ff.mg_cnt + 7'h01;
                  if (st_ff.mg_cnt >= MG_PRE_LAST)
                  begin
                     nxt_st.mdio_o   = st_ff.mg_shift[31];
                     nxt_st.mg_shift = {st_ff.mg_shift[30:0], 1'b0};
                  end
                  // Reads hand the pin to the PHY at turnaround
                  nxt_st.mdio_oe = !(st_ff.mg_read && (st_ff.mg_cnt + 7'h01) >= MG_TA_BIT);
               end
            end
            else
               nxt_st.mg_div = st_ff.mg_div + 16'h0001;
         end
         default:
         begin
            nxt_st.mg_state = MG_IDLE;
         end
      endcase

      // Transmit pins change just after each tx clock rise
      if (tx_rise)
      begin
         if (tx_nib_valid_i)
         begin
            nxt_st.txen = 1'b1;
            nxt_st.txd  = st_ff.serial ? {3'h0, tx_nib_data_i[0]} : tx_nib_data_i;
            nxt_st.txer = tx_nib_err_i;
         end
         else
         begin
            // Drops just after the first rise that finds no nibble
            nxt_st.txen = 1'b0;
            nxt_st.txd  = 4'h0;
            nxt_st.txer = 1'b0;
         end
      end

      // Buffer fill; CRC bytes are counted like any data
      if (rx_frame_end_i)
      begin
         nxt_st.rx_last_len = st_ff.rx_cnt + CNT_W'(rx_byte_i);
         nxt_st.rx_end      = 1'b1;
         nxt_st.rx_cnt      = '0;
      end
      else if (rx_byte_i)
      begin
         if (st_ff.buf_size != '0 && (st_ff.rx_cnt + 1'b1) == {st_ff.buf_size, BUF_PAD})
         begin
            nxt_st.rx_full = 1'b1;
            nxt_st.rx_cnt  = '0;
         end
         else
            nxt_st.rx_cnt = st_ff.rx_cnt + 1'b1;
      end

      // Address recognition result
      if (rx_da_valid_i)
      begin
         nxt_st.rx_decide = 1'b1;
         nxt_st.rx_accept = dec_acc;
         nxt_st.rx_miss   = dec_miss;
         nxt_st.rx_flush  = !dec_acc;
      end

      // Synchronous reset
      if (!nrst_i)
      begin
         nxt_st        = '0;
         nxt_st.max_frame_length = MAX_FRAME_LENGTH_RST;
      end
   end

   // State register
   always_ff @(posedge sys_clk_i)
   begin
      st_ff <= nxt_st;
   end

   // Outputs
   assign reg_rdata_o       = st_ff.rdata;
   assign mgmt_data_clock_o = st_ff.mdc;
   assign mgmt_data_o       = st_ff.mdio_o;
   assign mgmt_data_oe_o    = st_ff.mdio_oe;
   assign tx_nib_ready_o    = tx_rise;
   assign tx_frame_valid_o  = st_ff.txen;
   assign tx_nibble_data_o  = st_ff.txd;
   assign tx_error_out_o    = st_ff.txer;
   assign rx_decide_o       = st_ff.rx_decide;
   assign rx_accept_o       = st_ff.rx_accept;
   assign rx_miss_o         = st_ff.rx_miss;
   assign rx_flush_o        = st_ff.rx_flush;
   assign rx_buf_full_o     = st_ff.rx_full;
   assign rx_last_valid_o   = st_ff.rx_end;
   assign rx_last_len_o     = st_ff.rx_last_len;
   assign rx_ring_start_o   = {st_ff.rx_ring, 2'h0};
   assign tx_ring_start_o   = {st_ff.tx_ring, 2'h0};

   // Checks
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!nrst_i);

   sequence s_bcast_open;
      rx_da_valid_i && (rx_da_i == BCAST_DA) && !st_ff.broadcast_reject;
   endsequence
   sequence s_plain_accept;
      rx_decide_o && rx_accept_o && !rx_miss_o;
   endsequence
   sequence s_mg_start;
      reg_wr_i && (reg_addr_i == OFF_MG_FRAME) && (st_ff.mg_state == MG_IDLE);
   endsequence

   mdio_after_reset_a: assert property ($rose(nrst_i) |-> !mgmt_data_oe_o)
      else $error("management pin driven after reset");
   mdio_idle_a: assert property ((st_ff.mg_state == MG_IDLE) |-> !mgmt_data_oe_o && !mgmt_data_clock_o)
      else $error("management pin or clock active while idle");
   mdio_start_a: assert property (s_mg_start |=> mgmt_data_oe_o && mgmt_data_o [*3])
      else $error("management preamble not started");
   mdio_sync_a: assert property ($changed(mgmt_data_o) && mgmt_data_oe_o && $past(mgmt_data_oe_o) |-> $fell(mgmt_data_clock_o))
      else $error("management data moved off the falling clock");
   txen_edge_a: assert property ($changed(tx_frame_valid_o) |-> $past(tx_rise))
      else $error("frame valid changed away from tx clock edge");
   txd_quiet_a: assert property (!tx_frame_valid_o |-> tx_nibble_data_o == 4'h0 && !tx_error_out_o)
      else $error("transmit data active outside frame");
   ring_low_a: assert property ($past(reg_rd_i) && $past(reg_addr_i) == OFF_RX_RING |-> reg_rdata_o[1:0] == 2'h0)
      else $error("ring pointer low bits not zero");
   bufsize_low_a: assert property ($past(reg_rd_i) && $past(reg_addr_i) == OFF_BUF_SIZE |-> reg_rdata_o[3:0] == 4'h0)
      else $error("buffer size low bits not zero");
   bcast_accept_a: assert property (s_bcast_open |=> s_plain_accept)
      else $error("open broadcast not accepted");
   pause_reject_a: assert property (rx_da_valid_i && st_ff.fc_en && rx_pause_i && rx_da_i == PAUSE_DA |=> rx_decide_o && !rx_accept_o)
      else $error("PAUSE frame not rejected");
   exact_accept_a: assert property (rx_da_valid_i && !rx_da_i[IG_BIT] && da_exact && !(st_ff.fc_en && rx_pause_i) |=> s_plain_accept)
      else $error("exact unicast not accepted");
   miss_promiscuous_accept_a: assert property (rx_decide_o && rx_miss_o |-> rx_accept_o && $past(st_ff.promiscuous_accept))
      else $error("miss flag without promiscuous accept");
   reject_flush_a: assert property (rx_da_valid_i ##1 (rx_decide_o && !rx_accept_o) |-> rx_flush_o)
      else $error("rejected frame not flushed");
endmodule

/* test/erf_phy_model.sv */
module erf_phy_model
(
   // Management wire as the device leaves it
   input  wire logic mg_drive_i,
   input  wire logic mg_oe_i,
   // Pins seen by the device
   output logic      mg_level_o,
   output logic      tx_clk_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // PHY transmit clock runs free at 8 MHz
   initial tx_clk_o = 1'b0;
   always #62.5 tx_clk_o = ~tx_clk_o;
   // Pull-up holds the wire high once the device lets go
   assign mg_level_o = mg_oe_i ? mg_drive_i : 1'b1;
endmodule

/* test/test_enet_rx_filter_mii_tx.sv */
module test_enet_rx_filter_mii_tx;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk_i = 0, nrst_i = 0, reg_wr_i = 0, reg_rd_i = 0, tx_nib_valid_i = 0;
   logic tx_nib_err_i = 0, rx_da_valid_i = 0, rx_pause_i = 0, rx_byte_i = 0, rx_frame_end_i = 0;
   logic mgmt_data_i, tx_nibble_clock_i, mgmt_data_clock_o, mgmt_data_o, mgmt_data_oe_o;
   logic tx_nib_ready_o, tx_frame_valid_o, tx_error_out_o, rx_decide_o, rx_accept_o, rx_miss_o;
   logic rx_flush_o, rx_buf_full_o, rx_last_valid_o;
   logic [7:0]  reg_addr_i = '0;
   logic [31:0] reg_wdata_i = '0, reg_rdata_o, rx_ring_start_o, tx_ring_start_o, q, seed;
   logic [3:0]  tx_nib_data_i = '0, tx_nibble_data_o;
   logic [47:0] rx_da_i = '0, st, da;
   logic [10:0] rx_last_len_o;
   logic [7:0]  offs [4] = '{8'h04, 8'h08, 8'h0c, 8'h40};
   logic [31:0] msk [4] = '{32'hffff_fffc, 32'hffff_fffc, 32'h0000_07f0, 32'h0000_0000};
   int miscompares = 0, checks_done = 0, cyc = 0;
   logic [7:0]  n;
   logic [63:0] ht;
   localparam logic [47:0] BC = 48'hffff_ffff_ffff;
   // Fast management clock keeps the frame short
   erf_top #(.MDC_HALF(2)) dut (.sys_clk_i, .nrst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
      .reg_rd_i, .reg_rdata_o, .mgmt_data_clock_o, .mgmt_data_i, .mgmt_data_o, .mgmt_data_oe_o,
      .tx_nib_valid_i, .tx_nib_data_i, .tx_nib_err_i, .tx_nib_ready_o, .tx_nibble_clock_i,
      .tx_frame_valid_o, .tx_nibble_data_o, .tx_error_out_o, .rx_da_valid_i, .rx_da_i,
      .rx_pause_i, .rx_decide_o, .rx_accept_o, .rx_miss_o, .rx_flush_o, .rx_byte_i,
      .rx_frame_end_i, .rx_buf_full_o, .rx_last_valid_o, .rx_last_len_o, .rx_ring_start_o,
      .tx_ring_start_o);
   erf_phy_model phy (.mg_drive_i(mgmt_data_o), .mg_oe_i(mgmt_data_oe_o),
      .mg_level_o(mgmt_data_i), .tx_clk_o(tx_nibble_clock_i));
   always #5 sys_clk_i = ~sys_clk_i;
   // Xorshift source, seeded once
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // Pins expected for a held nibble and its error flag in either mode
   function automatic logic [5:0] tx_exp(input logic ser, input logic [4:0] d);
      return {1'b1, d[4], ser ? {3'h0, d[0]} : d[3:0]};
   endfunction
   // Hash table bit an address should pick: top six bits of its CRC
   function automatic logic [5:0] hidx(input logic [47:0] a);
      logic [31:0] c;
      c = '1;
      for (int k = 0; k < 48; k++)
         c = {c[30:0], 1'b0} ^ ((c[31] ^ a[40 - 8*(k/8) + k%8]) ? 32'h04c1_1db7 : 32'h0);
      return c[31:26];
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
         miscompares++;
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, d};
      @(posedge sys_clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rreg(input logic [7:0] a, output logic [31:0] v);
      @(posedge sys_clk_i);
      {reg_rd_i, reg_addr_i} <= {1'b1, a};
      @(posedge sys_clk_i);
      reg_rd_i <= 1'b0;
      #1 v = reg_rdata_o;
   endtask
   // One address decision, sampled in its single decide cycle
   task automatic flt(input logic [47:0] a, input logic ps, input logic acc, input logic ms);
      @(posedge sys_clk_i);
      {rx_da_valid_i, rx_da_i, rx_pause_i} <= {1'b1, a, ps};
      @(posedge sys_clk_i);
      rx_da_valid_i <= 1'b0;
      #1 chk({rx_decide_o, rx_accept_o, rx_miss_o, rx_flush_o}, {1'b1, acc, ms, ~acc});
   endtask
   // Hang guard
   always @(posedge sys_clk_i)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         miscompares++;
         results();
      end
   end
   initial
   begin
      seed = 32'h0000_0a91;
      repeat (2) @(posedge sys_clk_i);
      nrst_i <= 1'b1;
      #1 chk({mgmt_data_oe_o, mgmt_data_clock_o, tx_frame_valid_o}, 0);
      foreach (offs[i])
      begin
         da[31:0] = rnd();
         wreg(offs[i], da[31:0]);
         rreg(offs[i], q);
         chk(q, da[31:0] & msk[i]);
         if (i < 2) chk(i ? tx_ring_start_o : rx_ring_start_o, da[31:0] & msk[i]);
      end
      $display("register test done");
      st = 48'({rnd(), rnd()}) & 48'hfeff_ffff_ffff;
      da = 48'({rnd(), rnd()}) & 48'hfeff_ffff_ffff;
      wreg(8'h00, 0);
      wreg(8'h20, st[47:16]);
      wreg(8'h24, {st[15:0], 16'h0000});
      flt(BC, 0, 1, 0);
      flt(st, 0, 1, 0);
      flt(da, 0, 0, 0);
      flt(da | 48'h0100_0000_0000, 0, 0, 0);
      ht = 64'h1 << hidx(da | 48'h0100_0000_0000);
      wreg(8'h10, ht[63:32]);
      wreg(8'h14, ht[31:0]);
      flt(da | 48'h0100_0000_0000, 0, 1, 0);
      wreg(8'h18, '1);
      wreg(8'h1c, '1);
      flt(da, 0, 1, 0);
      wreg(8'h18, 0);
      wreg(8'h1c, 0);
      wreg(8'h00, 32'h0000_0018);
      flt(BC, 0, 1, 1);
      flt(da, 0, 1, 1);
      wreg(8'h00, 32'h0000_0010);
      flt(BC, 0, 0, 0);
      wreg(8'h00, 32'h0010_0020);
      flt(48'h0180_c200_0001, 1, 0, 0);
      flt(st, 1, 0, 0);
      wreg(8'h0c, 32'h0000_0010);
      n = 0;
      for (int k = 1; k <= 16; k++)
      begin
         @(posedge sys_clk_i);
         {rx_byte_i, rx_frame_end_i} <= {1'b1, k == 16};
         #1 n += rx_buf_full_o;
      end
      @(posedge sys_clk_i);
      {rx_byte_i, rx_frame_end_i} <= 2'b00;
      #1 chk({n[3:0], rx_last_valid_o, rx_last_len_o}, {4'h0, 1'b1, 11'h010});
      $display("filter test done");
      for (int m = 0; m < 2; m++)
      begin
         wreg(8'h00, {25'h0, m[0], 6'h0});
         q = rnd();
         {tx_nib_valid_i, tx_nib_err_i, tx_nib_data_i} <= {1'b1, q[4:0]};
         n = 0;
         repeat (40)
         begin
            @(posedge sys_clk_i);
            #1 n += tx_nib_ready_o;
         end
         chk({tx_frame_valid_o, tx_error_out_o, tx_nibble_data_o},
            tx_exp(m[0], q[4:0]));
         chk(n == 3 || n == 4, 1);
         @(posedge sys_clk_i);
         tx_nib_valid_i <= 1'b0;
         repeat (40) @(posedge sys_clk_i);
         #1 chk({tx_frame_valid_o, tx_error_out_o, tx_nibble_data_o}, 0);
      end
      $display("transmit test done");
      wreg(8'h28, 32'h2000_0000);
      #1 chk({mgmt_data_oe_o, mgmt_data_o}, 2'h3);
      repeat (300) @(posedge sys_clk_i);
      rreg(8'h2c, q);
      chk(q[1:0], 2'h1);
      rreg(8'h28, q);
      chk(q[15:0], 16'hffff);
      $display("management test done");
      results();
   end
endmodule
